// File: rtl/bldc_ctrl_pkg.sv
// Shared constants, types and register map of the motor control block
`default_nettype none
package bldc_ctrl_pkg;
  // ****************************************************************
  // Register map (byte offsets on the register port)
  // ****************************************************************
  localparam logic [7:0] SPEED_LO_ADDR = 8'h00;  // speed command bits 7:0
  localparam logic [7:0] SPEED_HI_ADDR = 8'h01;  // speed command bit 8 in bit 0
  localparam logic [7:0] CTRL_ADDR     = 8'h02;
  localparam logic [7:0] FAULT_ADDR    = 8'h03;  // fault cause, cleared by read
  localparam logic [7:0] STATUS_ADDR   = 8'h10;  // fault and state flags

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  // Status flags, bit 7 down to bit 0
  typedef struct packed {
    logic       thermal_shutdown_flag;  // bit 7
    logic       low_power_flag;         // bit 6
    logic       overcurrent_flag;       // bit 5
    logic       rotor_lock_flag;        // bit 4
    logic [3:0] reserved;               // bits 3:0 read zero
  } status_t;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] reserved;                  // bits 7:4 read zero
    logic       regulator_voltage_select;  // bit 3: 0 = 5 V, 1 = 3.3 V
    logic       low_power_inhibit;         // bit 2
    logic       serial_speed_select;       // bit 1: command from register
    logic       speed_input_select;        // bit 0: 0 = analog, 1 = pulse width
  } ctrl_t;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [8:0] SPEED_RESET    = 9'h000;
  localparam logic [3:0] FAULT_NONE     = 4'h0;
  localparam logic [3:0] FAULT_ROTOR_LK = 4'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 100;
  localparam int LOCK_OFF_MS    = 5000;   // lock release time
  localparam int ENTER_ANA_US   = 5200;   // entry qualification, analog
  localparam int ENTER_PWM_US   = 58000;  // entry qualification, pulse width
  localparam int EXIT_US        = 1000;   // exit qualification
  localparam int SPEED_WINDOW   = 511;    // pulse-width sample window, cycles

  // ****************************************************************
  // Modulation
  // ****************************************************************
  localparam int ANGLE_STEPS    = 24;     // 15 degree steps per cycle
  localparam int PHASE_SHIFT    = 8;      // 120 degrees in steps

  typedef enum logic {
    LP_RUN = 1'b0,
    LP_LOW = 1'b1
  } lp_state_t;
endpackage
`default_nettype wire

// File: rtl/bldc_wave_rom.sv
// Flat-bottom sine table with a registered read port
`default_nettype none
module bldc_wave_rom (
  // Clock
  input  wire logic       ref_clk,
  // Read port
  input  wire logic [4:0] angle,
  output logic      [7:0] level_r
);
  logic [7:0] level_nxt;

  // Sine plus third harmonic, shifted so the lowest phase sits at zero
  always_comb begin
    case (angle)
      5'd0, 5'd12:                  level_nxt = 8'h80;
      5'd1, 5'd11:                  level_nxt = 8'hB4;
      5'd2, 5'd6, 5'd10:            level_nxt = 8'hDD;
      5'd3, 5'd5, 5'd7, 5'd9:       level_nxt = 8'hF6;
      5'd4, 5'd8:                   level_nxt = 8'hFF;
      5'd13, 5'd23:                 level_nxt = 8'h42;
      default:                      level_nxt = 8'h00;
    endcase
  end

  // Registered output keeps the multiplier path short
  always_ff @(posedge ref_clk) begin
    level_r <= level_nxt;
  end
endmodule
`default_nettype wire

// File: rtl/bldc_ctrl_top.sv
// Speed command, protection, low-power sequencing and phase modulation
// ****************************************************************
// ****************************************************************
`default_nettype none
module bldc_ctrl_top #(
  parameter int LOCK_OFF_CYC  = bldc_ctrl_pkg::LOCK_OFF_MS * 1000 * bldc_ctrl_pkg::CLK_MHZ,
  parameter int ENTER_ANA_CYC = bldc_ctrl_pkg::ENTER_ANA_US * bldc_ctrl_pkg::CLK_MHZ,
  parameter int ENTER_PWM_CYC = bldc_ctrl_pkg::ENTER_PWM_US * bldc_ctrl_pkg::CLK_MHZ,
  parameter int EXIT_CYC      = bldc_ctrl_pkg::EXIT_US * bldc_ctrl_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Asynchronous comparator and pin levels
  input  wire logic       speed_pin,
  input  wire logic       speed_below_entry,
  input  wire logic       speed_above_exit,
  input  wire logic       temp_over_trip,
  input  wire logic       temp_below_release,
  input  wire logic       vcc_at_fall,
  input  wire logic       vcc_at_rise,
  input  wire logic       fet_overcurrent,
  input  wire logic       sleep_variant,
  // Same-clock inputs from converter and commutation logic
  input  wire logic [8:0] speed_adc_code,
  input  wire logic [8:0] duty_limit,
  input  wire logic       rotor_lock_detect,
  input  wire logic [4:0] elec_angle,
  // Register port behind the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_r,
  // Power stage and supply controls
  output logic      [2:0] phase_pwm_r,
  output logic            phase_drive_en_r,
  output logic      [8:0] output_peak_duty_r,
  output logic            reg_target_3v3_r,
  output logic            regulator_en_r,
  output logic            serial_en_r,
  output logic            low_power_r
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [8:0] pin_meta_r;
  logic [8:0] pin_sync_r;

  // Two flops per pin; only the second stage is read by logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta_r <= 9'h000;
      pin_sync_r <= 9'h000;
    end else begin
      pin_meta_r <= {speed_pin, speed_below_entry, speed_above_exit, temp_over_trip,
                     temp_below_release, vcc_at_fall, vcc_at_rise, fet_overcurrent,
                     sleep_variant};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic s_speed, s_below, s_above, s_temp_trip, s_temp_rel;
  logic s_vfall, s_vrise, s_oc, s_sleep_var;
  assign {s_speed, s_below, s_above, s_temp_trip, s_temp_rel,
          s_vfall, s_vrise, s_oc, s_sleep_var} = pin_sync_r;

  // ****************************************************************
  // Registers
  // ****************************************************************
  bldc_ctrl_pkg::ctrl_t     ctrl_r;
  bldc_ctrl_pkg::status_t   status;
  bldc_ctrl_pkg::lp_state_t lp_state_r;
  logic [8:0] speed_cmd_reg_r;
  logic [3:0] fault_cause_r;
  logic       oc_flag_r;
  logic       thermal_r;
  logic       uvlo_r;
  logic       lock_hold_r;
  logic       lp_enter;
  logic       serial_live;
  logic       drive_ok;

  // Sleep variant powers the serial port down while low
  assign serial_live = !(s_sleep_var && lp_state_r == bldc_ctrl_pkg::LP_LOW);

  // Software-written state; sleep entry drops all volatile settings
  always_ff @(posedge ref_clk) begin
    if (rst || (lp_enter && s_sleep_var)) begin
      ctrl_r          <= bldc_ctrl_pkg::CTRL_RESET;
      speed_cmd_reg_r <= bldc_ctrl_pkg::SPEED_RESET;
    end else if (reg_wr && serial_live) begin
      case (reg_addr)
        bldc_ctrl_pkg::SPEED_LO_ADDR: speed_cmd_reg_r[7:0] <= reg_wdata;
        bldc_ctrl_pkg::SPEED_HI_ADDR: speed_cmd_reg_r[8]   <= reg_wdata[0];
        bldc_ctrl_pkg::CTRL_ADDR:     ctrl_r               <= {4'h0, reg_wdata[3:0]};
        default: ;
      endcase
    end
  end

  assign status = '{thermal_shutdown_flag: thermal_r,
                    low_power_flag:        lp_state_r == bldc_ctrl_pkg::LP_LOW,
                    overcurrent_flag:      oc_flag_r,
                    rotor_lock_flag:       lock_hold_r,
                    reserved:              4'h0};

  // Read data; unmapped offsets and a powered-down port read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (!serial_live) begin
        reg_rdata_r <= 8'h00;
      end else begin
        case (reg_addr)
          bldc_ctrl_pkg::SPEED_LO_ADDR: reg_rdata_r <= speed_cmd_reg_r[7:0];
          bldc_ctrl_pkg::SPEED_HI_ADDR: reg_rdata_r <= {7'h00, speed_cmd_reg_r[8]};
          bldc_ctrl_pkg::CTRL_ADDR:     reg_rdata_r <= ctrl_r;
          bldc_ctrl_pkg::FAULT_ADDR:    reg_rdata_r <= {4'h0, fault_cause_r};
          bldc_ctrl_pkg::STATUS_ADDR:   reg_rdata_r <= status;
          default:                      reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Protection
  // ****************************************************************
  logic        rd_status;
  logic        rd_fault;
  logic [31:0] lock_cnt_r;

  assign rd_status = reg_rd && serial_live && reg_addr == bldc_ctrl_pkg::STATUS_ADDR;
  assign rd_fault  = reg_rd && serial_live && reg_addr == bldc_ctrl_pkg::FAULT_ADDR;

  // Thermal hysteresis: trip level sets, release level clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thermal_r <= 1'b0;
    end else if (s_temp_trip) begin
      thermal_r <= 1'b1;
    end else if (s_temp_rel) begin
      thermal_r <= 1'b0;
    end
  end

  // Lockout from reset until the supply is seen at the rising level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uvlo_r <= 1'b1;
    end else if (s_vfall) begin
      uvlo_r <= 1'b1;
    end else if (s_vrise) begin
      uvlo_r <= 1'b0;
    end
  end

  // Sticky trip flag; a trip in the read cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oc_flag_r <= 1'b0;
    end else if (s_oc) begin
      oc_flag_r <= 1'b1;
    end else if (rd_status) begin
      oc_flag_r <= 1'b0;
    end
  end

  // Lock: stop at once, hold off for the release time, then retry
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_hold_r <= 1'b0;
      lock_cnt_r  <= 32'h0000_0000;
    end else if (lock_hold_r) begin
      if (lock_cnt_r == 32'(LOCK_OFF_CYC - 1)) begin
        lock_hold_r <= 1'b0;
        lock_cnt_r  <= 32'h0000_0000;
      end else begin
        lock_cnt_r  <= lock_cnt_r + 32'h0000_0001;
      end
    end else if (rotor_lock_detect && drive_ok) begin
      lock_hold_r <= 1'b1;
    end
  end

  // Cause is recorded on lock entry; entry wins over a clearing read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_cause_r <= bldc_ctrl_pkg::FAULT_NONE;
    end else if (rotor_lock_detect && drive_ok) begin
      fault_cause_r <= bldc_ctrl_pkg::FAULT_ROTOR_LK;
    end else if (rd_fault) begin
      fault_cause_r <= bldc_ctrl_pkg::FAULT_NONE;
    end
  end

  // Every stop reason removes the drive
  assign drive_ok = !thermal_r && !uvlo_r && !s_oc && !lock_hold_r &&
                    lp_state_r == bldc_ctrl_pkg::LP_RUN;

  // ****************************************************************
  // Sleep and standby sequencing
  // ****************************************************************
  logic        pwm_mode;
  logic        entry_cond;
  logic        exit_cond;
  logic        qual_cond;
  logic        qual_done;
  logic [31:0] qual_need;
  logic [31:0] qual_cnt_r;

  assign pwm_mode = ctrl_r.speed_input_select;

  // Entry per source; serial mode uses the pulse-width timing
  assign entry_cond = ctrl_r.serial_speed_select ? (speed_cmd_reg_r == 9'h000) :
                      pwm_mode ? !s_speed : s_below;
  // Serial write wakes standby only; sleep wakes from the pin
  assign exit_cond  = (ctrl_r.serial_speed_select && !s_sleep_var) ?
                      (speed_cmd_reg_r != 9'h000) : (pwm_mode ? s_speed : s_above);
  // Inhibit gates entry only, so it never pulls the block out
  assign qual_cond  = (lp_state_r == bldc_ctrl_pkg::LP_RUN) ?
                      (entry_cond && !ctrl_r.low_power_inhibit) : exit_cond;
  assign qual_need  = (lp_state_r == bldc_ctrl_pkg::LP_LOW) ? 32'(EXIT_CYC) :
                      (pwm_mode || ctrl_r.serial_speed_select) ? 32'(ENTER_PWM_CYC) :
                      32'(ENTER_ANA_CYC);
  assign qual_done  = qual_cond && qual_cnt_r == qual_need - 32'h0000_0001;
  assign lp_enter   = qual_done && lp_state_r == bldc_ctrl_pkg::LP_RUN;

  // Qualification timer restarts whenever its condition lapses
  always_ff @(posedge ref_clk) begin
    if (rst || !qual_cond || qual_done) begin
      qual_cnt_r <= 32'h0000_0000;
    end else begin
      qual_cnt_r <= qual_cnt_r + 32'h0000_0001;
    end
  end

  // Two-state power sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lp_state_r <= bldc_ctrl_pkg::LP_RUN;
    end else begin
      case (lp_state_r)
        bldc_ctrl_pkg::LP_RUN: if (qual_done) lp_state_r <= bldc_ctrl_pkg::LP_LOW;
        bldc_ctrl_pkg::LP_LOW: if (qual_done) lp_state_r <= bldc_ctrl_pkg::LP_RUN;
        default:               lp_state_r <= bldc_ctrl_pkg::LP_RUN;
      endcase
    end
  end

  // Supply and interface controls
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_target_3v3_r <= 1'b0;
      regulator_en_r   <= 1'b1;
      serial_en_r      <= 1'b1;
      low_power_r      <= 1'b0;
    end else begin
      reg_target_3v3_r <= ctrl_r.regulator_voltage_select;
      regulator_en_r   <= serial_live;
      serial_en_r      <= serial_live;
      low_power_r      <= lp_state_r == bldc_ctrl_pkg::LP_LOW;
    end
  end

  // ****************************************************************
  // Speed command and peak duty
  // ****************************************************************
  logic [8:0] win_cnt_r;
  logic [8:0] high_cnt_r;
  logic [8:0] pin_duty_r;
  logic [8:0] speed_cmd;

  // Pulse width measured as high samples over a fixed window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_cnt_r  <= 9'h000;
      high_cnt_r <= 9'h000;
      pin_duty_r <= 9'h000;
    end else if (win_cnt_r == 9'(bldc_ctrl_pkg::SPEED_WINDOW - 1)) begin
      win_cnt_r  <= 9'h000;
      high_cnt_r <= 9'h000;
      pin_duty_r <= high_cnt_r + {8'h00, s_speed};
    end else begin
      win_cnt_r  <= win_cnt_r + 9'h001;
      high_cnt_r <= high_cnt_r + {8'h00, s_speed};
    end
  end

  // Source select
  assign speed_cmd = ctrl_r.serial_speed_select ? speed_cmd_reg_r :
                     pwm_mode ? pin_duty_r : speed_adc_code;

  // Clamp by surge, current or acceleration limits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_peak_duty_r <= 9'h000;
    end else begin
      output_peak_duty_r <= (speed_cmd > duty_limit) ? duty_limit : speed_cmd;
    end
  end

  // ****************************************************************
  // Phase modulation
  // ****************************************************************
  logic [7:0] carrier_r;
  logic [7:0] wave_q      [3];
  logic [7:0] phase_lvl_r [3];

  // Free-running carrier for the phase comparators
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_r <= 8'h00;
    end else begin
      carrier_r <= carrier_r + 8'h01;
    end
  end

  // One table lookup and scaling per phase, 120 degrees apart
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic [5:0]  angle_sum;
    logic [4:0]  angle;
    logic [16:0] scaled;

    assign angle_sum = {1'b0, elec_angle} + 6'(i * bldc_ctrl_pkg::PHASE_SHIFT);
    assign angle     = (angle_sum >= 6'(bldc_ctrl_pkg::ANGLE_STEPS)) ?
                       5'(angle_sum - 6'(bldc_ctrl_pkg::ANGLE_STEPS)) : angle_sum[4:0];
    assign scaled    = {9'h000, wave_q[i]} * {8'h00, output_peak_duty_r};

    bldc_wave_rom u_rom (
      .ref_clk (ref_clk),
      .angle   (angle),
      .level_r (wave_q[i])
    );

    // Peak duty sets the amplitude; the lowest phase stays at ground
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        phase_lvl_r[i] <= 8'h00;
        phase_pwm_r[i] <= 1'b0;
      end else begin
        phase_lvl_r[i] <= scaled[16:9];
        phase_pwm_r[i] <= drive_ok && (carrier_r < phase_lvl_r[i]);
      end
    end
  end

  // Drivers released to high impedance on any stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_drive_en_r <= 1'b0;
    end else begin
      phase_drive_en_r <= drive_ok;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_lock_start;
    rotor_lock_detect && drive_ok;
  endsequence
  // Drive enable is registered, so it drops one cycle after the hold is taken
  sequence s_lock_held;
    lock_hold_r ##1 (lock_hold_r && !phase_drive_en_r);
  endsequence

  property p_oc_hiz;
    s_oc |=> !phase_drive_en_r && !phase_pwm_r[0] && !phase_pwm_r[1] && !phase_pwm_r[2];
  endproperty
  a_oc_hiz: assert property (p_oc_hiz) else $error("drivers on during overcurrent");

  property p_oc_flag;
    s_oc |=> oc_flag_r ##1 (oc_flag_r || $past(rd_status));
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag not held");

  property p_thermal;
    s_temp_trip |=> thermal_r ##1 !phase_drive_en_r;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal trip did not stop drive");

  property p_uvlo;
    uvlo_r && !s_vrise |=> uvlo_r;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout left without rising level");

  property p_lock;
    s_lock_start |=> (fault_cause_r == bldc_ctrl_pkg::FAULT_ROTOR_LK) ##0 s_lock_held;
  endproperty
  a_lock: assert property (p_lock) else $error("lock entry not handled");

  property p_lock_flag;
    rd_status && lock_hold_r |=> reg_rdata_r[4];
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock flag not reported");

  property p_inhibit;
    lp_state_r == bldc_ctrl_pkg::LP_RUN && ctrl_r.low_power_inhibit
      |=> lp_state_r == bldc_ctrl_pkg::LP_RUN;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("entered low power while inhibited");

  property p_low_stop;
    lp_state_r == bldc_ctrl_pkg::LP_LOW |=> !phase_drive_en_r && low_power_r;
  endproperty
  a_low_stop: assert property (p_low_stop) else $error("drive during low power");

  property p_qual_restart;
    !qual_cond |=> qual_cnt_r == 32'h0000_0000 && $stable(lp_state_r);
  endproperty
  a_qual_restart: assert property (p_qual_restart) else $error("timer not restarted");

  property p_clamp;
    1'b1 |=> output_peak_duty_r <= $past(duty_limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("peak duty above limit");

  property p_reg_sel;
    ctrl_r.regulator_voltage_select |=> reg_target_3v3_r;
  endproperty
  a_reg_sel: assert property (p_reg_sel) else $error("regulator target wrong");

  // At every angle the table leaves one phase at level zero
  property p_one_grounded;
    phase_lvl_r[0] == 8'h00 || phase_lvl_r[1] == 8'h00 || phase_lvl_r[2] == 8'h00;
  endproperty
  a_one_grounded: assert property (p_one_grounded) else $error("no phase at ground");
endmodule
`default_nettype wire

// File: bench/bldc_host_model.sv
// Host model: one-cycle strobes on the register port
`default_nettype none
module bldc_host_model (
  // Clock and read data
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata_r,
  // Register strobes
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Request held over one edge, then read data taken as the strobe drops
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd} = 2'b00;
    q = reg_rdata_r;
  endtask
endmodule
`default_nettype wire

// File: bench/bldc_ctrl_tb_top.sv
// Self-checking bench of the motor control block
`default_nettype none
module bldc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst, speed_pin, temp_over_trip, temp_below_release;
  logic        vcc_at_rise, fet_overcurrent, sleep_variant, rotor_lock_detect;
  logic        speed_below_entry, vcc_at_fall;
  logic [4:0]  elec_angle;
  logic [8:0]  speed_adc_code, hi;
  logic [2:0]  seen;
  logic        reg_wr, reg_rd, phase_drive_en_r, reg_target_3v3_r;
  logic        regulator_en_r, serial_en_r, low_power_r;
  logic [2:0]  phase_pwm_r;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, q;
  logic [8:0]  duty_limit, output_peak_duty_r;
  int          n_fail = 0, checks_done = 0, cyc = 0;
  // Rows: offset, write value, read-back, regulator select afterwards
  logic [24:0] rows [5] = '{{8'h02, 8'h08, 8'h08, 1'b1}, {8'h02, 8'hf4, 8'h04, 1'b0},
    {8'h55, 8'haa, 8'h00, 1'b0}, {8'h10, 8'hff, 8'h00, 1'b0}, {8'h01, 8'hff, 8'h01, 1'b0}};

  bldc_ctrl_top #(.LOCK_OFF_CYC(50), .ENTER_ANA_CYC(20), .ENTER_PWM_CYC(30),
    .EXIT_CYC(10)) bldc_ctrl_top_inst (.speed_above_exit(speed_pin), .*);
  bldc_host_model bldc_host_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard: the sequence needs about 1000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    bldc_host_model_inst.acc(w, a, d, q);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst, speed_pin, temp_over_trip, fet_overcurrent, sleep_variant} = 5'b11000;
    {rotor_lock_detect, temp_below_release, vcc_at_rise} = 3'b011;
    {speed_below_entry, vcc_at_fall, elec_angle} = 7'h00;
    speed_adc_code = 9'h080;
    duty_limit = 9'h1ff;
    wt(4);
    rst = 1'b0;
    chk(regulator_en_r, 1'b1);
    foreach (rows[i]) begin
      acc(1'b1, rows[i][24:17], rows[i][16:9]);
      acc(1'b0, rows[i][24:17], 8'h00);
      chk(q, rows[i][8:1]);
      chk(reg_target_3v3_r, rows[i][0]);
    end
    // Register command, clamped then unclamped; speed is 0x1ff here
    acc(1'b1, 8'h02, 8'h02);
    acc(1'b1, 8'h00, 8'hff);
    duty_limit = 9'h0c0;
    wt(4);
    chk(output_peak_duty_r, 9'h0c0);
    duty_limit = 9'h1ff;
    wt(4);
    chk(output_peak_duty_r, 9'h1ff);
    acc(1'b1, 8'h00, 8'h00);
    acc(1'b1, 8'h01, 8'h00);
    wt(40);
    chk(low_power_r, 1'b1);
    acc(1'b1, 8'h00, 8'h10);
    wt(20);
    chk(low_power_r, 1'b0);
    // Standby then sleep variant, pin-driven, with an interrupted entry
    for (int v = 0; v < 2; v++) begin
      sleep_variant = v[0];
      acc(1'b1, 8'h02, 8'h01);
      speed_pin = 1'b0;
      wt(25);
      chk(low_power_r, 1'b0);
      speed_pin = 1'b1;
      wt(3);
      speed_pin = 1'b0;
      wt(40);
      chk(low_power_r, 1'b1);
      chk(phase_drive_en_r, 1'b0);
      chk(serial_en_r, !v[0]);
      chk(regulator_en_r, !v[0]);
      acc(1'b1, 8'h02, 8'h05);
      acc(1'b0, 8'h10, 8'h00);
      chk(q, v ? 9'h000 : 9'h040);
      chk(low_power_r, 1'b1);
      speed_pin = 1'b1;
      wt(20);
      chk(low_power_r, 1'b0);
      acc(1'b0, 8'h02, 8'h00);
      chk(q, v ? 9'h000 : 9'h005);
    end
    // Protection: overcurrent, thermal trip, rotor lock
    fet_overcurrent = 1'b1;
    wt(4);
    chk(phase_drive_en_r, 1'b0);
    fet_overcurrent = 1'b0;
    acc(1'b0, 8'h10, 8'h00);
    chk(q[5], 1'b1);
    {temp_over_trip, temp_below_release} = 2'b10;
    wt(4);
    chk(phase_drive_en_r, 1'b0);
    acc(1'b0, 8'h10, 8'h00);
    chk(q[7], 1'b1);
    {temp_over_trip, temp_below_release} = 2'b01;
    wt(6);
    rotor_lock_detect = 1'b1;
    wt(3);
    rotor_lock_detect = 1'b0;
    acc(1'b0, 8'h10, 8'h00);
    chk(q[4], 1'b1);
    chk(phase_drive_en_r, 1'b0);
    acc(1'b0, 8'h03, 8'h00);
    chk(q, 9'h001);
    // Analog mode: below the entry level enters sleep, above the exit level leaves
    speed_below_entry = 1'b1;
    speed_pin = 1'b0;
    wt(26);
    chk(low_power_r, 1'b1);
    speed_below_entry = 1'b0;
    speed_pin = 1'b1;
    wt(15);
    chk(low_power_r, 1'b0);
    // Lockout: the falling level locks, only the rising level releases
    {vcc_at_fall, vcc_at_rise} = 2'b10;
    wt(4);
    chk(phase_drive_en_r, 1'b0);
    vcc_at_fall = 1'b0;
    wt(6);
    chk(phase_drive_en_r, 1'b0);
    vcc_at_rise = 1'b1;
    wt(15);
    chk(phase_drive_en_r, 1'b1);
    // Half-scale analog command: peak phase high about half of each carrier period
    speed_adc_code = 9'h100;
    for (int a = 0; a < 2; a++) begin
      elec_angle = 5'(a * 8);
      wt(4);
      chk(output_peak_duty_r, 9'h100);
      hi = 9'h000;
      seen = 3'b000;
      repeat (256) begin
        hi = hi + 9'(phase_pwm_r[1 - a]);
        seen = seen | phase_pwm_r;
        wt(1);
      end
      chk(seen[2 - a], 1'b0);
      chk(hi > 9'h07a && hi < 9'h081, 1'b1);
    end
    summarize();
  end
endmodule
`default_nettype wire
